// *** core/clk_status_pkg.sv ***
// constants for the clock status, flag and source select block
package clk_status_pkg;
	// register indices, not byte addresses (printed offsets are not multiples of four: byte address is index * 4)
	localparam logic [7:0] idx_post_divide = 8'h36;
	localparam logic [7:0] idx_status_flags = 8'h37;
	localparam logic [7:0] idx_irq_enables = 8'h38;
	localparam logic [7:0] idx_source_select = 8'h39;
	localparam logic [7:0] idx_synth_config = 8'h34;
	localparam logic [7:0] idx_guard = 8'h3b;
	localparam logic [7:0] idx_clock_ctrl = 8'h3c;
	localparam logic [7:0] idx_reset_cause = 8'h3d;
	localparam int addr_w = 12;
	// status flag bit positions
	localparam int flg_tick = 7;
	localparam int flg_por = 6;
	localparam int flg_lvr = 5;
	localparam int flg_lock_chg = 4;
	localparam int flg_lock = 3;
	localparam int flg_bad_address_reset_flag = 2;
	localparam int flg_osc_chg = 1;
	localparam int flg_osc = 0;
	// clock source select bit positions
	localparam int sel_pll = 7;
	localparam int sel_stop_keeps_osc = 6;
	localparam int sel_pre = 3;
	localparam int sel_pce = 2;
	localparam int sel_rtiosc = 1;
	localparam int sel_coposc = 0;
	// bits writable in normal mode apart from the watchdog source
	localparam logic [7:0] sel_normal_mask = 8'hce;
	localparam logic [7:0] sel_reset = 8'h80;
	localparam logic [7:0] irq_en_mask = 8'h92;
	localparam logic [7:0] flag_clear_mask = 8'hf6;
	localparam logic [7:0] post_divide_value_reset = 8'h03;
	localparam logic [4:0] post_divide_value_mask = 5'h1f;
	// fixed divide while not settled, and bus divide from the pll clock
	localparam logic [5:0] unlocked_div = 6'h04;
	localparam logic [5:0] bus_div = 6'h02;
	// axi response codes
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [1:0] {
		wr_idle = 2'b00,
		wr_resp = 2'b01
	} wr_state_t;
endpackage

// *** core/clk_status_flags.sv ***
// clock status flags, interrupt enables and clock source select with axi4-lite access
`timescale 1ns/1ps
// Notes on behaviour
// - post divide writes only while pll selected
// - pll clock is vco/4 until settled
// - bus clock is pll clock over two
// - tick flag bit 7 set each period
// - power-on flag set by power-on reset only
// - brownout flag set by brownout or power-on
// - bad address flag set, cleared by power-on
// - flags cleared by writing one only
// - settle change flag on either edge
// - settled status bit 3 is read-only
// - oscillator change flag on either edge
// - qualified status cleared in full stop
// - losing settle drops qualified, except pseudo stop
// - enables at bits 7, 4 and 1
// - source select writable only when guard clear
// - special mode all bits, normal mode subset
// - watchdog source write-once, one retry after loss
// - pll always runs; software programs it
// - qualified loss forces pll source select
// - synth config write clears settled and qualified while pll selected and guard clear
module clk_status_flags #(
	parameter int div_w = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic poweron_reset,
	input wire logic brownout_reset,
	input wire logic bad_address_reset,
	input wire logic tick_period_end,
	input wire logic pll_in_tolerance,
	input wire logic osc_filter_ok,
	input wire logic full_stop_entry,
	input wire logic pseudo_stop_entry,
	input wire logic special_mode,
	input wire logic watchdog_write_once,
	input wire logic [clk_status_pkg::addr_w-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [clk_status_pkg::addr_w-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pll_div_ratio_valid,
	output logic [div_w-1:0] pll_div_ratio,
	output logic [div_w-1:0] bus_div_ratio,
	output logic can_osc_clk_en,
	output logic tick_irq,
	output logic pll_settle_irq,
	output logic osc_change_irq
);
	import clk_status_pkg::*;

	logic [7:0] status_flags;
	logic [7:0] clock_irq_enables;
	logic [7:0] clock_source_select;
	logic [4:0] post_divide_value;
	logic cfg_write_guard;
	logic pll_settled;
	logic osc_qualified;
	logic watchdog_locked;
	logic watchdog_retry;
	logic [addr_w-1:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic w_held;
	wr_state_t wr_state;
	logic wr_fire;
	logic wr_mapped;
	logic [7:0] wbyte;
	logic next_settled;
	logic next_qualified;
	logic synth_write;
	logic w_strb_low;
	logic tick_flag, por_flag, lvr_flag, settle_chg_flag, bad_address_reset_flag_flag, osc_chg_flag;

	// byte address to register index
	function automatic logic [7:0] reg_index(input logic [addr_w-1:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == idx_post_divide) || (i == idx_status_flags) || (i == idx_irq_enables) ||
			(i == idx_source_select) || (i == idx_synth_config) || (i == idx_guard) ||
			(i == idx_clock_ctrl) || (i == idx_reset_cause);
	endfunction

	// write takes place once both address and data are held
	assign wr_fire = aw_held && w_held && (wr_state == wr_idle);
	assign wr_mapped = is_mapped(reg_index(aw_addr)) && (aw_addr[1:0] == 2'b00);
	assign wbyte = w_strb_low ? w_data[7:0] : 8'h00; // lane 0 only
	assign synth_write = wr_fire && wr_mapped && reg_index(aw_addr) == idx_synth_config &&
		!cfg_write_guard && clock_source_select[sel_pll];

	// address channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && wr_state == wr_idle;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
		end
	end

	// data channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb_low <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid && wr_state == wr_idle;
			if (s_axi_wready && s_axi_wvalid) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb_low <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= wr_idle;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			case (wr_state)
				wr_idle: begin
					if (wr_fire) begin
						wr_state <= wr_resp;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
					end
				end
				wr_resp: begin
					if (s_axi_bready) begin
						wr_state <= wr_idle;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wr_state <= wr_idle;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// read channel, one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= is_mapped(reg_index(s_axi_araddr)) ? resp_okay : resp_slverr;
				case (reg_index(s_axi_araddr))
					idx_post_divide: s_axi_rdata <= {27'h0, post_divide_value};
					idx_status_flags: s_axi_rdata <= {24'h0, status_flags};
					idx_irq_enables: s_axi_rdata <= {24'h0, clock_irq_enables};
					idx_source_select: s_axi_rdata <= {24'h0, clock_source_select};
					idx_guard: s_axi_rdata <= {31'h0, cfg_write_guard};
					idx_clock_ctrl: s_axi_rdata <= {30'h0, watchdog_retry, watchdog_locked};
					default: s_axi_rdata <= 32'h0;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// settled and qualified status tracking
	always_comb begin
		next_settled = pll_in_tolerance;
		next_qualified = osc_filter_ok;
		if (synth_write) begin
			next_settled = 1'b0;
			next_qualified = 1'b0;
		end
		if (!next_settled && !pseudo_stop_entry) begin
			next_qualified = 1'b0;
		end
		if (full_stop_entry) begin
			next_qualified = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_settled <= 1'b0;
			osc_qualified <= 1'b0;
		end else begin
			pll_settled <= next_settled;
			osc_qualified <= next_qualified;
		end
	end

	// sticky flags: hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_flag <= 1'b0;
			settle_chg_flag <= 1'b0;
			osc_chg_flag <= 1'b0;
		end else begin
			if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_status_flags) begin
				tick_flag <= tick_flag & ~wbyte[flg_tick];
				settle_chg_flag <= settle_chg_flag & ~wbyte[flg_lock_chg];
				osc_chg_flag <= osc_chg_flag & ~wbyte[flg_osc_chg];
			end
			if (tick_period_end) begin
				tick_flag <= 1'b1;
			end
			if (next_settled != pll_settled) begin
				settle_chg_flag <= 1'b1;
			end
			if (next_qualified != osc_qualified) begin
				osc_chg_flag <= 1'b1;
			end
		end
	end

	// reset cause flags: system reset leaves them alone
	always_ff @(posedge aclk) begin
		if (poweron_reset) begin
			por_flag <= 1'b1;
			lvr_flag <= 1'b1;
			bad_address_reset_flag_flag <= 1'b0;
		end else begin
			if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_status_flags) begin
				por_flag <= por_flag & ~wbyte[flg_por];
				lvr_flag <= lvr_flag & ~wbyte[flg_lvr];
				bad_address_reset_flag_flag <= bad_address_reset_flag_flag & ~wbyte[flg_bad_address_reset_flag];
			end
			if (brownout_reset) begin
				lvr_flag <= 1'b1;
			end
			if (bad_address_reset) begin
				bad_address_reset_flag_flag <= 1'b1;
			end
		end
	end

	// register image, bit 7 down to 0; live status bits 3 and 0 are read-only
	assign status_flags = {tick_flag, por_flag, lvr_flag, settle_chg_flag,
		pll_settled, bad_address_reset_flag_flag, osc_chg_flag, osc_qualified};

	// interrupt enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_irq_enables <= 8'h00;
		end else if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_irq_enables) begin
			clock_irq_enables <= wbyte & irq_en_mask;
		end
	end

	// configuration write guard
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_write_guard <= 1'b0;
		end else if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_guard) begin
			cfg_write_guard <= wbyte[0];
		end
	end

	// post divide value, writable only with pll selected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			post_divide_value <= post_divide_value_reset[4:0];
		end else if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_post_divide &&
				clock_source_select[sel_pll]) begin
			post_divide_value <= wbyte[4:0] & post_divide_value_mask;
		end
	end

	// watchdog source write-once tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_locked <= 1'b0;
			watchdog_retry <= 1'b0;
		end else begin
			if (watchdog_write_once) begin
				watchdog_locked <= 1'b1;
			end
			if (!next_qualified && clock_source_select[sel_coposc]) begin
				watchdog_retry <= 1'b1;
			end else if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_source_select &&
					!cfg_write_guard && !special_mode && watchdog_locked && wbyte[sel_coposc]) begin
				watchdog_retry <= 1'b0;
			end
		end
	end

	// clock source select with write permissions and forced values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_source_select <= sel_reset;
		end else begin
			if (wr_fire && wr_mapped && reg_index(aw_addr) == idx_source_select && !cfg_write_guard) begin
				if (special_mode) begin
					clock_source_select <= wbyte;
				end else begin
					clock_source_select <= (wbyte & sel_normal_mask) |
						(clock_source_select & ~sel_normal_mask);
					if (!watchdog_locked || (watchdog_retry && wbyte[sel_coposc])) begin
						clock_source_select[sel_coposc] <= wbyte[sel_coposc];
					end
				end
				if (!osc_qualified && !wbyte[sel_pll]) begin
					clock_source_select[sel_pll] <= 1'b1;
				end
			end
			if (!next_qualified || full_stop_entry) begin
				clock_source_select[sel_pll] <= 1'b1;
				clock_source_select[sel_rtiosc] <= 1'b0;
				clock_source_select[sel_coposc] <= 1'b0;
			end
		end
	end

	// divide ratios, can gate and interrupt requests, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_div_ratio <= div_w'(unlocked_div);
			pll_div_ratio_valid <= 1'b0;
			bus_div_ratio <= div_w'(bus_div);
			can_osc_clk_en <= 1'b0;
			tick_irq <= 1'b0;
			pll_settle_irq <= 1'b0;
			osc_change_irq <= 1'b0;
		end else begin
			pll_div_ratio <= pll_settled ? div_w'(post_divide_value) + 1'b1 : div_w'(unlocked_div);
			pll_div_ratio_valid <= pll_settled;
			bus_div_ratio <= div_w'(bus_div);
			can_osc_clk_en <= osc_qualified;
			tick_irq <= status_flags[flg_tick] & clock_irq_enables[flg_tick];
			pll_settle_irq <= status_flags[flg_lock_chg] & clock_irq_enables[flg_lock_chg];
			osc_change_irq <= status_flags[flg_osc_chg] & clock_irq_enables[flg_osc_chg];
		end
	end
endmodule

// *** tb/clk_status_flags_props.sv ***
// port assertions for the clock status flags block
`timescale 1ns/1ps
module clk_status_flags_props #(
	parameter int div_w = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pll_in_tolerance,
	input wire logic osc_filter_ok,
	input wire logic full_stop_entry,
	input wire logic pseudo_stop_entry,
	input wire logic s_axi_bvalid,
	input wire logic pll_div_ratio_valid,
	input wire logic [div_w-1:0] pll_div_ratio,
	input wire logic [div_w-1:0] bus_div_ratio,
	input wire logic can_osc_clk_en,
	input wire logic tick_irq,
	input wire logic pll_settle_irq,
	input wire logic osc_change_irq
);
	import clk_status_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// divide ratios
	property p_bus_div;
		bus_div_ratio == div_w'(bus_div);
	endproperty
	a_bus_div: assert property (p_bus_div) else $error("bus divide not two");
	property p_unlocked_div;
		!pll_div_ratio_valid |-> pll_div_ratio == div_w'(unlocked_div);
	endproperty
	a_unlocked_div: assert property (p_unlocked_div) else $error("unsettled divide not four");
	// settled status follows the tolerance input
	property p_settle_rise;
		$rose(pll_div_ratio_valid) |-> $past(pll_in_tolerance, 2);
	endproperty
	a_settle_rise: assert property (p_settle_rise) else $error("settled without tolerance");
	property p_unsettled;
		!pll_in_tolerance [*3] |-> !pll_div_ratio_valid;
	endproperty
	a_unsettled: assert property (p_unsettled) else $error("settled stuck high");
	// qualified status and the gated oscillator clock
	property p_osc_lost;
		!osc_filter_ok [*3] |-> !can_osc_clk_en;
	endproperty
	a_osc_lost: assert property (p_osc_lost) else $error("osc clock kept while unqualified");
	property p_full_stop;
		full_stop_entry [*3] |-> !can_osc_clk_en;
	endproperty
	a_full_stop: assert property (p_full_stop) else $error("osc clock kept in full stop");
	property p_lock_loss;
		$fell(pll_in_tolerance) && !pseudo_stop_entry |-> ##[1:4] !can_osc_clk_en;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("qualified kept after settle loss");
	// requests drop only after a software write
	property p_irq_clear;
		$fell(tick_irq) || $fell(pll_settle_irq) || $fell(osc_change_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("request dropped without write");
	c_settle_irq: cover property ($rose(pll_settle_irq));
	c_osc_drop: cover property ($fell(can_osc_clk_en));
	c_tick_irq: cover property ($rose(tick_irq));
endmodule

// *** tb/clk_status_flags_tb.sv ***
// self-checking bench for the clock status flags block
`timescale 1ns/1ps
module clk_status_flags_tb;
	import clk_status_pkg::*;
	localparam logic [11:0] a_syn = 12'hd0;
	localparam logic [11:0] a_pd = 12'hd8;
	localparam logic [11:0] a_fl = 12'hdc;
	localparam logic [11:0] a_en = 12'he0;
	localparam logic [11:0] a_sel = 12'he4;
	localparam logic [11:0] a_grd = 12'hec;
	localparam logic [11:0] a_res = 12'hfc;
	logic aclk, aresetn, poweron_reset, brownout_reset, bad_address_reset, tick_period_end;
	logic pll_in_tolerance, osc_filter_ok, full_stop_entry, pseudo_stop_entry, special_mode, watchdog_write_once;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic pll_div_ratio_valid, can_osc_clk_en, tick_irq, pll_settle_irq, osc_change_irq;
	logic [5:0] pll_div_ratio, bus_div_ratio;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	clk_status_flags #(.div_w(6)) i_clk_status_flags (.*);
	// clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic rst(input logic por);
		aresetn <= 1'b0;
		poweron_reset <= por;
		idle(2);
		aresetn <= 1'b1;
		poweron_reset <= 1'b0;
	endtask
	// one write: both channels offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = resp_okay);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	// one read, data in the low byte
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = resp_okay);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, {24'h0, e});
		check({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			finish_test;
		end
	end
	// main sequence
	initial begin
		{aresetn, brownout_reset, bad_address_reset, tick_period_end, pll_in_tolerance, osc_filter_ok} = '0;
		{full_stop_entry, pseudo_stop_entry, special_mode, watchdog_write_once} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		poweron_reset = 1'b1;
		rst(1'b1);
		rd(a_fl, 8'h60);
		rd(a_sel, 8'h80);
		rd(a_pd, 8'h03);
		rd(a_res, 8'h00, resp_slverr);
		wr(a_res, 8'hff, resp_slverr);
		$display("reset values done");
		wr(a_fl, 8'h00);
		rd(a_fl, 8'h60);
		wr(a_fl, 8'h40);
		rd(a_fl, 8'h20);
		bad_address_reset <= 1'b1;
		idle(1);
		bad_address_reset <= 1'b0;
		rd(a_fl, 8'h24);
		rst(1'b0);
		rd(a_fl, 8'h24);
		wr(a_fl, 8'h20);
		brownout_reset <= 1'b1;
		idle(1);
		brownout_reset <= 1'b0;
		rd(a_fl, 8'h24);
		rst(1'b1);
		rd(a_fl, 8'h60);
		$display("reset cause done");
		s_axi_wstrb <= 4'h0;
		wr(a_en, 8'hff);
		rd(a_en, 8'h00);
		s_axi_wstrb <= 4'h1;
		wr(a_en, 8'hff);
		rd(a_en, 8'h92);
		pll_in_tolerance <= 1'b1;
		idle(3);
		rd(a_fl, 8'h78);
		check(32'(pll_settle_irq), 1);
		wr(a_fl, 8'h68);
		rd(a_fl, 8'h18);
		wr(a_fl, 8'h10);
		check(32'(pll_settle_irq), 0);
		wr(a_pd, 8'h07);
		rd(a_pd, 8'h07);
		check(32'(pll_div_ratio), 8);
		$display("pll settle done");
		osc_filter_ok <= 1'b1;
		idle(3);
		rd(a_fl, 8'h0b);
		check(32'(osc_change_irq), 1);
		check(32'(can_osc_clk_en), 1);
		wr(a_fl, 8'h02);
		wr(a_sel, 8'h4f);
		rd(a_sel, 8'h4f);
		wr(a_pd, 8'h01);
		rd(a_pd, 8'h07);
		wr(a_grd, 8'h01);
		rd(a_grd, 8'h01);
		wr(a_sel, 8'h80);
		rd(a_sel, 8'h4f);
		wr(a_grd, 8'h00);
		watchdog_write_once <= 1'b1;
		idle(1);
		watchdog_write_once <= 1'b0;
		wr(a_sel, 8'h4e);
		rd(a_sel, 8'h4f);
		osc_filter_ok <= 1'b0;
		idle(3);
		rd(a_sel, 8'hcc);
		rd(a_fl, 8'h0a);
		osc_filter_ok <= 1'b1;
		idle(3);
		wr(a_sel, 8'h4d);
		rd(a_sel, 8'h4d);
		wr(a_sel, 8'h4c);
		rd(a_sel, 8'h4d);
		special_mode <= 1'b1;
		wr(a_sel, 8'h4c);
		rd(a_sel, 8'h4c);
		special_mode <= 1'b0;
		wr(a_sel, 8'hcc);
		rd(a_sel, 8'hcc);
		$display("source select done");
		wr(a_fl, 8'h12);
		wr(a_syn, 8'h00);
		idle(4);
		rd(a_fl, 8'h1b);
		wr(a_fl, 8'h12);
		pseudo_stop_entry <= 1'b1;
		pll_in_tolerance <= 1'b0;
		idle(3);
		rd(a_fl, 8'h11);
		pseudo_stop_entry <= 1'b0;
		pll_in_tolerance <= 1'b1;
		idle(3);
		wr(a_fl, 8'h10);
		pll_in_tolerance <= 1'b0;
		idle(3);
		rd(a_fl, 8'h12);
		pll_in_tolerance <= 1'b1;
		full_stop_entry <= 1'b1;
		idle(3);
		check(32'(can_osc_clk_en), 0);
		full_stop_entry <= 1'b0;
		$display("settle loss done");
		tick_period_end <= 1'b1;
		idle(1);
		tick_period_end <= 1'b0;
		idle(2);
		check(32'(tick_irq), 1);
		wr(a_en, 8'h00);
		check(32'(tick_irq), 0);
		wr(a_en, 8'h80);
		check(32'(tick_irq), 1);
		wr(a_fl, 8'h80);
		check(32'(tick_irq), 0);
		$display("tick done");
		finish_test;
	end
endmodule
bind clk_status_flags clk_status_flags_props #(.div_w(div_w)) i_clk_status_flags_props (.*);
